// file: core/barrel_shifter.sv
/*
 * logarithmic barrel shifter, left with zero fill or right with a chosen fill bit.
 * purely combinational; assumes the caller registers the result.
 */
`timescale 1ns/1ps
module barrel_shifter #(
   parameter int WIDTH = 64,
   parameter int CNT_W = 6
) (
   input wire logic [WIDTH-1:0] operand_in,
   input wire logic [CNT_W-1:0] count_in,
   input wire logic right_in,
   input wire logic fill_in,
   output logic [WIDTH-1:0] result_out
);

   // stage[s] holds the value after the first s count bits are applied
   logic [WIDTH-1:0] stage [CNT_W+1];

   assign stage[0] = operand_in;

   // one stage per count bit, shifting by a power of two when the bit is set
   genvar s;
   generate
      for (s = 0; s < CNT_W; s++) begin : g_stage
         localparam int STEP = 2 ** s;
         logic [WIDTH-1:0] moved;
         always_comb begin
            if (right_in) begin
               moved = {{STEP{fill_in}}, stage[s][WIDTH-1:STEP]};
            end else begin
               moved = {stage[s][WIDTH-1-STEP:0], {STEP{1'b0}}};
            end
         end
         assign stage[s+1] = count_in[s] ? moved : stage[s];
      end
   endgenerate

   assign result_out = stage[CNT_W];

endmodule

// file: core/integer_shift_unit.sv
/*
 * integer shift execution unit: six word and extended shifts, reserved
 * bit checking, plus a small register port with sticky event status.
 * assumes one request per cycle from decode, synchronous inputs, and that
 * the register file applies dest_out when its write bit is set.
 */
// How it works
// [RULE1] register count: low 5 or 6 bits
// [RULE2] immediate count: instruction bits 4:0 or 5:0
// [RULE3] both left shifts: 64-bit, zero fill
// [RULE4] logical word right: low half, upper zero
// [RULE5] logical extended right: 64 bits, zero fill
// [RULE6] arithmetic word right: bit 31 fills upward
// [RULE7] arithmetic extended right: bit 63 fills
// [RULE8] zero count: no move, upper treatment kept
// [RULE9] condition codes never change
// [RULE10] word shifts: bits 11:5 nonzero traps
// [RULE11] extended shifts: reserved bits trap per selectors
// [RULE12] trapping shift writes no destination
`timescale 1ns/1ps
`include "shift_unit_regs.svh"
module integer_shift_unit #(
   parameter int ADDR_W = 4,
   parameter int CC_W = 8
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic op_valid_in,
   input wire shift_pkg::shift_req_t shift_req_in,
   input wire logic [CC_W-1:0] cc_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output shift_pkg::dest_wr_t dest_out,
   output logic illegal_operation_exception_out,
   output logic [CC_W-1:0] cc_out,
   output logic [31:0] reg_rdata_out,
   output logic irq_out
);

   // decoded view of the request
   logic [5:0] shift_count;       // effective shift count
   logic [5:0] raw_count;         // six bits from register or instruction
   logic is_word;                 // one of the 32-bit forms
   logic known_op;                // code is one of the six operations
   logic rsv_narrow;              // any of bits 11:5 set
   logic rsv_wide;                // any of bits 11:6 set
   logic illegal;                 // reserved bits violated
   logic [63:0] operand;          // value handed to the shifter
   logic shift_right;             // direction
   logic fill_bit;                // bit shifted in from the top
   logic [63:0] shifted;          // shifter output
   logic [63:0] final_result;     // shifter output after upper-half treatment

   // count selection and reserved-field check
   always_comb begin
      raw_count = shift_req_in.immediate_select ?
         shift_req_in.instr[`SHU_CNT_WIDE_MSB:0] :                       // [RULE2]
         shift_req_in.source_register_two[`SHU_CNT_WIDE_MSB:0];          // [RULE1]
      // narrow count drops bit 5 so a stray bit cannot shift past 31
      if (shift_req_in.extended_select) begin
         shift_count = raw_count;
      end else begin
         shift_count = {1'b0, raw_count[`SHU_CNT_NARROW_MSB:0]};         // [RULE1] [RULE2]
      end
      rsv_narrow = |shift_req_in.instr[`SHU_RSV_HI:`SHU_RSV_LO_NARROW];
      rsv_wide = |shift_req_in.instr[`SHU_RSV_HI:`SHU_RSV_LO_WIDE];
      is_word = 1'b0;
      known_op = 1'b1;
      unique case (shift_req_in.op)
         shift_pkg::shift_left_word,
         shift_pkg::shift_right_logical_word,
         shift_pkg::shift_right_arithmetic_word: begin
            is_word = 1'b1;
         end
         shift_pkg::shift_left_extended,
         shift_pkg::shift_right_logical_extended,
         shift_pkg::shift_right_arithmetic_extended: begin
            is_word = 1'b0;
         end
         default: begin
            // unused codes are ignored, never written back
            known_op = 1'b0;
         end
      endcase
      if (is_word) begin
         illegal = rsv_narrow;                                           // [RULE10]
      end else begin
         illegal = ((!shift_req_in.immediate_select || !shift_req_in.extended_select) && rsv_narrow)
            || (shift_req_in.extended_select && rsv_wide);               // [RULE11]
      end
   end

   // operand preparation: word right shifts see only the low half
   always_comb begin
      operand = shift_req_in.source_register_one;
      shift_right = 1'b1;
      fill_bit = 1'b0;
      unique case (shift_req_in.op)
         shift_pkg::shift_left_word,
         shift_pkg::shift_left_extended: begin
            shift_right = 1'b0;                                          // [RULE3]
         end
         shift_pkg::shift_right_logical_word: begin
            operand = {32'h0000_0000, shift_req_in.source_register_one[`SHU_WORD_MSB:0]}; // [RULE4]
         end
         shift_pkg::shift_right_arithmetic_word: begin
            fill_bit = shift_req_in.source_register_one[`SHU_WORD_MSB];  // [RULE6]
            operand = {{32{fill_bit}}, shift_req_in.source_register_one[`SHU_WORD_MSB:0]};
         end
         shift_pkg::shift_right_logical_extended: begin
            fill_bit = 1'b0;                                             // [RULE5]
         end
         shift_pkg::shift_right_arithmetic_extended: begin
            fill_bit = shift_req_in.source_register_one[`SHU_DWORD_MSB]; // [RULE7]
         end
         default: begin
            shift_right = 1'b1;
         end
      endcase
   end

   barrel_shifter #(
      .WIDTH(64),
      .CNT_W(6)
   ) u_shifter (
      .operand_in(operand),
      .count_in(shift_count),
      .right_in(shift_right),
      .fill_in(fill_bit),
      .result_out(shifted)
   );

   // upper-half treatment of the word right shifts, applied even at count 0
   always_comb begin
      final_result = shifted;
      if (shift_req_in.op == shift_pkg::shift_right_logical_word) begin
         final_result = {32'h0000_0000, shifted[`SHU_WORD_MSB:0]};       // [RULE4] [RULE8]
      end else if (shift_req_in.op == shift_pkg::shift_right_arithmetic_word) begin
         final_result = {{32{shift_req_in.source_register_one[`SHU_WORD_MSB]}},
            shifted[`SHU_WORD_MSB:0]};                                   // [RULE6] [RULE8]
      end
   end

   // datapath state
   shift_pkg::dest_wr_t dest_reg, dest_next;
   logic illegal_reg, illegal_next;
   logic [CC_W-1:0] cc_reg, cc_next;

   // next values of the result stage
   always_comb begin
      dest_next.data = dest_reg.data;
      // a trapping shift leaves the destination untouched
      dest_next.write = op_valid_in && known_op && !illegal;             // [RULE12]
      if (op_valid_in && known_op && !illegal) begin
         dest_next.data = final_result;                                  // [RULE3] [RULE5] [RULE7]
      end
      illegal_next = op_valid_in && known_op && illegal;                 // [RULE10] [RULE11]
      // flags flow through unchanged; shifts have no flag result
      cc_next = cc_in;                                                   // [RULE9]
   end

   // result stage registers
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         dest_reg <= '0;
         illegal_reg <= 1'b0;
         cc_reg <= '0;
      end else begin
         dest_reg <= dest_next;
         illegal_reg <= illegal_next;
         cc_reg <= cc_next;
      end
   end

   // register port state
   logic [`SHU_EVT_WIDTH-1:0] status_reg, status_next;   // sticky events
   logic [`SHU_EVT_WIDTH-1:0] enable_reg, enable_next;   // interrupt enables
   logic [31:0] opcount_reg, opcount_next;               // completed shifts
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic [`SHU_EVT_WIDTH-1:0] events;
   logic [`SHU_EVT_WIDTH-1:0] clear_mask;

   // register next values: a set in the clearing cycle wins over the clear
   always_comb begin
      events = '0;
      events[`SHU_EVT_ILLEGAL] = illegal_next;
      events[`SHU_EVT_DONE] = dest_next.write;
      clear_mask = '0;
      enable_next = enable_reg;
      if (reg_wr_in && reg_addr_in == `SHU_CLEAR_OFF) begin
         clear_mask = reg_wdata_in[`SHU_EVT_WIDTH-1:0];
      end
      if (reg_wr_in && reg_addr_in == `SHU_ENABLE_OFF) begin
         enable_next = reg_wdata_in[`SHU_EVT_WIDTH-1:0];
      end
      status_next = (status_reg & ~clear_mask) | events;
      // the counter wraps; software takes differences
      opcount_next = dest_next.write ? opcount_reg + 32'h0000_0001 : opcount_reg;
      rdata_next = `SHU_RDATA_RESET;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            `SHU_STATUS_OFF: rdata_next = {{(32-`SHU_EVT_WIDTH){1'b0}}, status_reg};
            `SHU_ENABLE_OFF: rdata_next = {{(32-`SHU_EVT_WIDTH){1'b0}}, enable_reg};
            `SHU_OPCOUNT_OFF: rdata_next = opcount_reg;
            default: rdata_next = `SHU_RDATA_RESET;  // clear register and holes read zero
         endcase
      end
      irq_next = |(status_next & enable_next);
   end

   // register port flops
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         status_reg <= `SHU_EVT_RESET;
         enable_reg <= `SHU_EVT_RESET;
         opcount_reg <= `SHU_OPCOUNT_RESET;
         rdata_reg <= `SHU_RDATA_RESET;
         irq_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         enable_reg <= enable_next;
         opcount_reg <= opcount_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign dest_out = dest_reg;
   assign illegal_operation_exception_out = illegal_reg;
   assign cc_out = cc_reg;
   assign reg_rdata_out = rdata_reg;
   assign irq_out = irq_reg;

   // independent reference result for the checks below
   logic [63:0] ref_result;
   logic [31:0] ref_low;
   always_comb begin
      ref_low = shift_req_in.source_register_one[31:0];
      unique case (shift_req_in.op)
         shift_pkg::shift_right_logical_word:
            ref_result = {32'h0000_0000, ref_low >> shift_count};
         shift_pkg::shift_right_arithmetic_word:
            ref_result = {{32{ref_low[31]}}, 32'($signed(ref_low) >>> shift_count)};
         shift_pkg::shift_right_logical_extended:
            ref_result = shift_req_in.source_register_one >> shift_count;
         shift_pkg::shift_right_arithmetic_extended:
            ref_result = 64'($signed(shift_req_in.source_register_one) >>> shift_count);
         default:
            ref_result = shift_req_in.source_register_one << shift_count;
      endcase
   end

   logic legal_go;
   assign legal_go = op_valid_in && known_op && !illegal;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   chk_reg_count: assert property (op_valid_in && !shift_req_in.immediate_select |-> // [RULE1]
      shift_count == (shift_req_in.extended_select ? shift_req_in.source_register_two[5:0] :
      {1'b0, shift_req_in.source_register_two[4:0]})) else $error("register count wrong");
   chk_imm_count: assert property (op_valid_in && shift_req_in.immediate_select |-> // [RULE2]
      shift_count == (shift_req_in.extended_select ? shift_req_in.instr[5:0] :
      {1'b0, shift_req_in.instr[4:0]})) else $error("immediate count wrong");
   chk_left_result: assert property (legal_go && (shift_req_in.op == shift_pkg::shift_left_word || // [RULE3]
      shift_req_in.op == shift_pkg::shift_left_extended) |=> dest_out.write && dest_out.data == $past(ref_result))
      else $error("left shift result wrong");
   chk_srl_word: assert property (legal_go && shift_req_in.op == shift_pkg::shift_right_logical_word // [RULE4]
      |=> dest_out.data == $past(ref_result) && dest_out.data[63:32] == 32'h0000_0000)
      else $error("logical word shift wrong");
   chk_srl_ext: assert property (legal_go && shift_req_in.op == shift_pkg::shift_right_logical_extended // [RULE5]
      |=> dest_out.data == $past(ref_result)) else $error("logical extended shift wrong");
   chk_sra_word: assert property (legal_go && shift_req_in.op == shift_pkg::shift_right_arithmetic_word // [RULE6]
      |=> dest_out.data == $past(ref_result) && (&dest_out.data[63:31] || ~|dest_out.data[63:31]))
      else $error("arithmetic word shift wrong");
   chk_sra_ext: assert property (legal_go && shift_req_in.op == shift_pkg::shift_right_arithmetic_extended // [RULE7]
      |=> dest_out.data == $past(ref_result)) else $error("arithmetic extended shift wrong");
   chk_zero_count: assert property (legal_go && shift_count == 6'h00 && is_word && // [RULE8]
      shift_req_in.op != shift_pkg::shift_left_word |=> dest_out.data[31:0] ==
      $past(ref_low)) else $error("zero count moved bits");
   chk_flags_kept: assert property (##1 cc_out == $past(cc_in)) else $error("condition codes changed"); // [RULE9]
   chk_word_trap: assert property (op_valid_in && is_word && known_op && rsv_narrow |=> // [RULE10]
      illegal_operation_exception_out ##1 !illegal_operation_exception_out || $past(op_valid_in))
      else $error("word shift reserved bits not trapped");
   chk_ext_trap: assert property (op_valid_in && known_op && !is_word && shift_req_in.extended_select // [RULE11]
      && rsv_wide |=> illegal_operation_exception_out) else $error("extended shift reserved bits not trapped");
   // the narrow reserved field still binds an extended shift unless both selectors are set
   chk_ext_narrow: assert property (op_valid_in && known_op && !is_word && // [RULE11]
      !(shift_req_in.immediate_select && shift_req_in.extended_select) && rsv_narrow |=>
      illegal_operation_exception_out) else $error("extended shift narrow reserved bits not trapped");
   // a clean request must write and never trap, or a stuck trap would hide results
   chk_legal_write: assert property (legal_go |=> dest_out.write && // [RULE10]
      !illegal_operation_exception_out) else $error("legal shift trapped or not written");
   chk_no_write: assert property (illegal_operation_exception_out |-> !dest_out.write && // [RULE12]
      $stable(dest_out.data)) else $error("trapping shift wrote destination");

   cov_trap: cover property (illegal_operation_exception_out ##1 dest_out.write);
   cov_sra_word: cover property (legal_go && shift_req_in.op == shift_pkg::shift_right_arithmetic_word);
   cov_irq: cover property (irq_out && reg_wr_in && reg_addr_in == `SHU_CLEAR_OFF);
   cov_imm_six: cover property (legal_go && !is_word && shift_req_in.immediate_select &&
      shift_req_in.extended_select && shift_req_in.instr[5]);

endmodule

// file: core/shift_pkg.sv
/*
 * types shared by the shift unit: operation codes and the request and
 * destination-write carriers.
 * assumes the decode stage encodes operations as shift_op_t.
 */
package shift_pkg;

   // operation codes; codes 6 and 7 are unused
   typedef enum logic [2:0] {
      shift_left_word = 3'h0,
      shift_right_logical_word = 3'h1,
      shift_right_arithmetic_word = 3'h2,
      shift_left_extended = 3'h3,
      shift_right_logical_extended = 3'h4,
      shift_right_arithmetic_extended = 3'h5
   } shift_op_t;

   // one issued shift operation
   typedef struct packed {
      shift_op_t op;
      logic immediate_select;
      logic extended_select;
      logic [31:0] instr;
      logic [63:0] source_register_one;
      logic [63:0] source_register_two;
   } shift_req_t;

   // destination register write
   typedef struct packed {
      logic write;
      logic [63:0] data;
   } dest_wr_t;

endpackage

// file: core/shift_unit_regs.svh
/*
 * register offsets, field positions, reset values and instruction field
 * positions for the integer shift unit.
 * assumes a 4-bit word-aligned byte address on the plain register port.
 */
`ifndef SHIFT_UNIT_REGS_SVH
`define SHIFT_UNIT_REGS_SVH

// register byte offsets
`define SHU_STATUS_OFF 4'h0
`define SHU_CLEAR_OFF 4'h4
`define SHU_ENABLE_OFF 4'h8
`define SHU_OPCOUNT_OFF 4'hC

// event bits, same layout in status, clear and enable
`define SHU_EVT_WIDTH 2
`define SHU_EVT_ILLEGAL 0
`define SHU_EVT_DONE 1
`define SHU_EVT_RESET 2'h0
`define SHU_OPCOUNT_RESET 32'h0000_0000
`define SHU_RDATA_RESET 32'h0000_0000

// shift count fields
`define SHU_CNT_NARROW_MSB 4
`define SHU_CNT_WIDE_MSB 5

// reserved instruction field
`define SHU_RSV_HI 11
`define SHU_RSV_LO_NARROW 5
`define SHU_RSV_LO_WIDE 6

// word geometry
`define SHU_WORD_MSB 31
`define SHU_DWORD_MSB 63

`endif

// file: verif/dest_reg_file_model.sv
/*
 * behavioural model of the destination register that the shift unit writes.
 * assumes dest_in comes straight from the unit and one reset for both sides.
 */
`timescale 1ns/1ps
module dest_reg_file_model (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire shift_pkg::dest_wr_t dest_in,
   output logic [63:0] value_out
);
   logic [63:0] value_reg; // architectural copy of the destination
   logic [63:0] value_next;

   // only a raised write bit may change the register, stale data is ignored
   always_comb begin
      value_next = value_reg;
      if (dest_in.write === 1'b1) begin
         value_next = dest_in.data;
      end
   end

   // register stage, cleared with the unit
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         value_reg <= 64'h0;
      end else begin
         value_reg <= value_next;
      end
   end

   assign value_out = value_reg;
endmodule

// file: verif/integer_shift_unit_tb.sv
/*
 * self-checking bench for the integer shift unit: random shifts, reserved
 * bits, flags, event registers and interrupt.
 * assumes one clock and the register map of the unit's register header.
 */
`timescale 1ns/1ps
module integer_shift_unit_tb;
   // expected outcome of one issued shift
   typedef struct packed {
      logic trap;
      logic [63:0] data;
      logic [7:0] cc;
   } note_t;
   logic ref_clk_in, sys_rst_in, op_valid_in, reg_wr_in, reg_rd_in, irq_out;
   shift_pkg::shift_req_t shift_req_in;
   shift_pkg::dest_wr_t dest_out;
   logic [7:0] cc_in, cc_out;
   logic [3:0] reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, rd;
   logic illegal_operation_exception_out;
   logic [63:0] arch_value, arch_exp; // model register and its prediction
   note_t note_q[$]; // notes in issue order
   note_t mon_n;
   int err_count, checks, cycles, legal_ops;

   integer_shift_unit u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .op_valid_in(op_valid_in),
      .shift_req_in(shift_req_in), .cc_in(cc_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .dest_out(dest_out), .cc_out(cc_out),
      .illegal_operation_exception_out(illegal_operation_exception_out),
      .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
   dest_reg_file_model u_rf (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .dest_in(dest_out),
      .value_out(arch_value));

   // 200 MHz clock
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end

   // hang guard: the whole run needs far fewer cycles than this
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         test_done();
      end
   end

   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // reference result worked out from the shift definitions
   function automatic note_t predict(shift_pkg::shift_req_t r, logic [7:0] cc);
      note_t n;
      logic [5:0] cnt;
      logic [31:0] lo;
      logic wide;
      wide = (r.op == shift_pkg::shift_left_extended) || (r.op == shift_pkg::shift_right_logical_extended)
         || (r.op == shift_pkg::shift_right_arithmetic_extended);
      cnt = r.immediate_select ? r.instr[5:0] : r.source_register_two[5:0];
      if (!r.extended_select) begin
         cnt[5] = 1'b0;
      end
      lo = r.source_register_one[31:0];
      n.cc = cc;
      // bit 5 is only free for an extended shift with both selectors set
      n.trap = (r.instr[11:6] != 6'h0) || (r.instr[5] && !(wide && r.immediate_select && r.extended_select));
      case (r.op)
         shift_pkg::shift_right_logical_word: n.data = {32'h0, lo} >> cnt;
         shift_pkg::shift_right_arithmetic_word: n.data = $signed({{32{lo[31]}}, lo}) >>> cnt;
         shift_pkg::shift_right_logical_extended: n.data = r.source_register_one >> cnt;
         shift_pkg::shift_right_arithmetic_extended: n.data = $signed(r.source_register_one) >>> cnt;
         default: n.data = r.source_register_one << cnt;
      endcase
      return n;
   endfunction

   // one request per cycle, valid held high across a burst
   task automatic issue(shift_pkg::shift_req_t r);
      logic [7:0] c;
      c = 8'($urandom);
      @(posedge ref_clk_in);
      op_valid_in <= 1'b1;
      shift_req_in <= r;
      cc_in <= c;
      if (r.op <= shift_pkg::shift_right_arithmetic_extended) begin
         note_q.push_back(predict(r, c));
      end
   endtask

   // idle and let answers and the model register settle
   task automatic drain();
      @(posedge ref_clk_in);
      op_valid_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      #2;
      check("pending", 64'(note_q.size()), 64'h0);
      check("arch", arch_value, arch_exp);
   endtask

   // burst of every code incl. unused 6 and 7, boundary counts, optional bad reserved bits
   task automatic run_ops(int num, bit inject);
      shift_pkg::shift_req_t r;
      logic [5:0] bnd[5];
      logic [5:0] cnt;
      bnd = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h3F};
      for (int i = 0; i < num; i++) begin
         cnt = (i % 6 == 5) ? 6'($urandom) : bnd[i % 6];
         r.op = shift_pkg::shift_op_t'(3'(i % 8));
         r.immediate_select = 1'($urandom);
         r.extended_select = 1'($urandom);
         r.source_register_one = {$urandom, $urandom};
         r.source_register_two = {$urandom, $urandom};
         r.source_register_two[5:0] = cnt;
         r.instr = $urandom;
         r.instr[11:0] = {6'h0, cnt};
         if (!(r.op >= shift_pkg::shift_left_extended && r.immediate_select && r.extended_select)) begin
            r.instr[5] = 1'b0;
         end
         if (inject && ($urandom % 3 == 0)) begin
            r.instr[5 + ($urandom % 7)] = 1'b1;
         end
         issue(r);
      end
      drain();
   endtask

   task automatic reg_write(logic [3:0] a, logic [31:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      d = reg_rdata_out;
   endtask

   // scoreboard: each answer consumes the oldest note
   always @(posedge ref_clk_in) begin
      #1;
      if (!sys_rst_in && (dest_out.write !== 1'b0 || illegal_operation_exception_out !== 1'b0)) begin
         if (note_q.size() == 0) begin
            check("unexpected answer", 64'h1, 64'h0);
         end else begin
            mon_n = note_q.pop_front();
            check("trap", 64'(illegal_operation_exception_out), 64'(mon_n.trap));
            check("write", 64'(dest_out.write), 64'(!mon_n.trap));
            check("flags", 64'(cc_out), 64'(mon_n.cc));
            if (mon_n.trap) begin
               check("held data", dest_out.data, arch_exp);
            end else begin
               check("result", dest_out.data, mon_n.data);
               arch_exp = mon_n.data;
               legal_ops++;
            end
         end
      end
   end

   initial begin
      void'($urandom(32'h9C20A583));
      sys_rst_in = 1'b1;
      op_valid_in = 1'b0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      shift_req_in = '0;
      cc_in = 8'h00;
      reg_addr_in = 4'h0;
      reg_wdata_in = 32'h0;
      arch_exp = 64'h0;
      repeat (4) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      #1;
      check("reset irq", 64'(irq_out), 64'h0);
      check("reset dest", dest_out.data, 64'h0);
      check("reset flags", 64'(cc_out), 64'h0);
      check("reset rdata", 64'(reg_rdata_out), 64'h0);
      $display("test reset done");
      run_ops(240, 1'b0);
      $display("test legal shifts done");
      run_ops(240, 1'b1);
      $display("test reserved bits done");
      // interrupt: masked event, enabled event, clear, read-only status and write-only clear register
      reg_write(4'h4, 32'h3);
      reg_write(4'h8, 32'h1);
      reg_read(4'h8, rd);
      check("enable", 64'(rd), 64'h1);
      check("irq idle", 64'(irq_out), 64'h0);
      run_ops(1, 1'b0);
      check("irq masked", 64'(irq_out), 64'h0);
      reg_read(4'h0, rd);
      check("status done", 64'(rd), 64'h2);
      issue('{op: shift_pkg::shift_left_word, immediate_select: 1'b1, extended_select: 1'b0,
         instr: 32'h0000_0FE0, source_register_one: 64'h1, source_register_two: 64'h0});
      drain();
      check("irq raised", 64'(irq_out), 64'h1);
      reg_write(4'h0, 32'h0);
      reg_read(4'h0, rd);
      check("status both", 64'(rd), 64'h3);
      reg_read(4'h4, rd);
      check("clear reads zero", 64'(rd), 64'h0);
      reg_write(4'h4, 32'h1);
      #1;
      check("irq cleared", 64'(irq_out), 64'h0);
      reg_read(4'h0, rd);
      check("status left", 64'(rd), 64'h2);
      reg_read(4'hC, rd);
      check("op count", 64'(rd), 64'(legal_ops));
      $display("test interrupt done");
      test_done();
   end
endmodule
